// [hdl/tmr_pkg.sv]
// Constants, types and register map of the 8-bit timer slice.
// Assumes a classic Wishbone master and a 125 MHz system clock.
package tmr_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_TMR0_CTRL = 8'h00;
  localparam logic [7:0] OFS_TMR0 = 8'h04;
  localparam logic [7:0] OFS_TMR1_CTRL = 8'h08;
  localparam logic [7:0] OFS_TMR1 = 8'h0C;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h10;
  localparam logic [7:0] OFS_INT_CTRL = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;
  // Control register fields.
  localparam int CTL_MODE_LSB = 6;
  localparam int CTL_SRC = 5;
  localparam int CTL_RUN = 4;
  localparam int CTL_EDGE = 3;
  localparam int CTL_PSC_LSB = 0;
  localparam logic [7:0] CTL_RST = 8'h08;
  localparam logic [7:0] CTL1_MASK = 8'hF8;
  // System control fields.
  localparam int SYS_PFD_EN = 0;
  localparam int SYS_SRC = 1;
  // Interrupt control fields.
  localparam int INT_EN_LSB = 0;
  localparam int INT_FLAG_LSB = 4;
  // Port register fields.
  localparam int PRT_DIR_LSB = 0;
  localparam int PRT_DAT_LSB = 2;
  localparam int PRT_PULL_LSB = 4;
  localparam int PRT_PIN_LSB = 8;
  localparam logic [1:0] DIR_RST = 2'h3;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int PSC_W = 7;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_CAPTURE = 2'b11
  } tmr_mode_e;

  // Main block state.
  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] pre;
    logic [1:0] cap;
    logic [1:0] flag;
    logic [1:0] ien;
    logic [1:0] ovf;
    logic pfd_en;
    logic src;
    logic [1:0] dir_in;
    logic [1:0] odat;
    logic [1:0] pull;
    logic freq_divider_out;
    logic ack;
    logic [31:0] dat;
    logic wake;
  } tmr_state_s;

  typedef struct packed {
    logic [PSC_W-1:0] cnt;
    logic tick;
  } tmr_psc_s;

  typedef struct packed {
    logic [2:0] sh;
  } tmr_sync_s;
endpackage : tmr_pkg

// [hdl/tmr_sync_edge.sv]
// Two-stage synchroniser with rise and fall detection for one pin.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module tmr_sync_edge (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin and edges.
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  tmr_pkg::tmr_sync_s st;
  tmr_pkg::tmr_sync_s nxt;

  // Stage 0 feeds only stage 1; edges compare stages 1 and 2.
  always_comb
  begin
    nxt = st;
    nxt.sh = {st.sh[1:0], i_pin};
  end

  // Registers the shift chain.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= nxt;
  end

  // Edges seen in the clock the second stage takes the new level.
  assign o_rise = st.sh[1] & ~st.sh[2];
  assign o_fall = ~st.sh[1] & st.sh[2];
endmodule : tmr_sync_edge
`default_nettype wire

// [hdl/tmr_prescaler.sv]
// Power-of-two prescaler giving a one-cycle tick.
// Assumes i_tick is a one-cycle source pulse or held high.
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler #(
  parameter int W = 7
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Source tick and ratio.
  input wire logic i_tick,
  input wire logic [2:0] i_sel,
  output logic o_tick
);
  tmr_pkg::tmr_psc_s st;
  tmr_pkg::tmr_psc_s nxt;
  logic [W-1:0] mask;

  // Ratio 2**sel; code 0 passes every source tick.
  always_comb
  begin
    mask = W'((8'h01 << i_sel) - 8'h01);
    nxt = st;
    nxt.tick = 1'b0;
    if (i_tick)
    begin
      nxt.cnt = st.cnt + W'(1);
      nxt.tick = (st.cnt & mask) == mask;
    end
  end

  // Registers the divider.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= nxt;
  end

  assign o_tick = st.tick;
endmodule : tmr_prescaler
`default_nettype wire

// [hdl/tmr_top.sv]
// Two 8-bit timer/event counters with capture and frequency divider.
// Assumes a classic Wishbone master and a core that reports halt.
`timescale 1ns/1ps
`default_nettype none
module tmr_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Count pins, one per timer, and slow clock tick.
  input wire logic [1:0] i_count_pin,
  input wire logic i_slow_tick,
  output logic [1:0] o_count_pullup,
  // Divider pins: port_a_bit_three is 0, port_b_bit_four is 1.
  input wire logic [1:0] i_pfd_pin,
  output logic [1:0] o_pfd_pin,
  output logic [1:0] o_pfd_pin_oe,
  // Core side.
  input wire logic i_halted,
  output logic [1:0] o_irq_req,
  output logic o_wake
);
  tmr_pkg::tmr_state_s st;
  tmr_pkg::tmr_state_s nxt;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] tick;
  logic [1:0] start_e;
  logic [1:0] stop_e;
  logic [1:0] evt_e;
  logic [1:0] inhibit;
  logic [1:0] step;
  logic [1:0] run;
  logic req;
  logic wr;
  logic psc_src;
  logic psc_tick;
  logic [7:0] a;
  logic [31:0] rdata;
  tmr_pkg::tmr_mode_e mode [2];

  // Both count pins are synchronised before anything sees them.
  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    tmr_sync_edge u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_count_pin[g]),
      .o_rise(rise[g]),
      .o_fall(fall[g])
    );
  end

  // Only timer 0 has a prescaler.
  assign psc_src = st.ctrl[0][tmr_pkg::CTL_SRC] ? i_slow_tick : 1'b1;
  tmr_prescaler #(
    .W(tmr_pkg::PSC_W)
  ) u_psc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(psc_src),
    .i_sel(st.ctrl[0][2:0]),
    .o_tick(psc_tick)
  );

  // Timer clocks and edge roles per channel.
  always_comb
  begin
    a = i_wb_adr[7:0];
    req = i_wb_cyc & i_wb_stb;
    wr = req & i_wb_we & st.ack;
    tick[0] = psc_tick;
    tick[1] = st.ctrl[1][tmr_pkg::CTL_SRC] ? i_slow_tick : 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      mode[i] = tmr_pkg::tmr_mode_e'(st.ctrl[i][7:6]);
      run[i] = st.ctrl[i][tmr_pkg::CTL_RUN];
      // edge_sel 0 opens on fall and closes on rise.
      start_e[i] = st.ctrl[i][tmr_pkg::CTL_EDGE] ? rise[i] : fall[i];
      stop_e[i] = st.ctrl[i][tmr_pkg::CTL_EDGE] ? fall[i] : rise[i];
      evt_e[i] = st.ctrl[i][tmr_pkg::CTL_EDGE] ? fall[i] : rise[i];
    end
    // Reading the count or writing preload freezes that counter.
    inhibit[0] = req & (a == tmr_pkg::OFS_TMR0);
    inhibit[1] = req & (a == tmr_pkg::OFS_TMR1);
  end

  // Read mux; unmapped words read as zero.
  always_comb
  begin
    rdata = '0;
    case (a)
      tmr_pkg::OFS_TMR0_CTRL: rdata[7:0] = st.ctrl[0];
      tmr_pkg::OFS_TMR0: rdata[7:0] = st.cnt[0];
      tmr_pkg::OFS_TMR1_CTRL: rdata[7:0] = st.ctrl[1];
      tmr_pkg::OFS_TMR1: rdata[7:0] = st.cnt[1];
      tmr_pkg::OFS_SYS_CTRL: rdata[1:0] = {st.src, st.pfd_en};
      tmr_pkg::OFS_INT_CTRL:
      begin
        rdata[5:4] = st.flag;
        rdata[1:0] = st.ien;
      end
      tmr_pkg::OFS_PORT:
      begin
        rdata[9:8] = i_pfd_pin;
        rdata[5:0] = {st.pull, st.odat, st.dir_in};
      end
      default: rdata = '0;
    endcase
  end

  // Counting, capture, overflow, divider and register writes.
  always_comb
  begin
    nxt = st;
    nxt.ack = req & ~st.ack;
    nxt.ovf = '0;
    step = '0;
    if (req & ~st.ack)
      nxt.dat = rdata;
    for (int i = 0; i < 2; i++)
    begin
      if (!run[i])
        nxt.cap[i] = 1'b0;
      case (mode[i])
        tmr_pkg::MODE_TIMER: step[i] = run[i] & tick[i];
        tmr_pkg::MODE_EVENT: step[i] = run[i] & evt_e[i];
        tmr_pkg::MODE_CAPTURE:
        begin
          // Idle capture waits for an edge; a stopped one sees none.
          if (run[i] & ~st.cap[i] & start_e[i])
            nxt.cap[i] = 1'b1;
          else if (run[i] & st.cap[i] & stop_e[i])
          begin
            nxt.cap[i] = 1'b0;
            nxt.ctrl[i][tmr_pkg::CTL_RUN] = 1'b0;
          end
          else
            step[i] = run[i] & st.cap[i] & tick[i];
        end
        tmr_pkg::MODE_NONE: step[i] = 1'b0;
        default: step[i] = 1'b0;
      endcase
      // Overflow reloads on the same step and keeps counting.
      if (step[i] & ~inhibit[i])
      begin
        if (st.cnt[i] == tmr_pkg::CNT_MAX)
        begin
          nxt.cnt[i] = st.pre[i];
          nxt.ovf[i] = 1'b1;
        end
        else
          nxt.cnt[i] = st.cnt[i] + 8'h01;
      end
    end
    // Selected overflow toggles the divider.
    if (nxt.ovf[st.src])
      nxt.freq_divider_out = ~st.freq_divider_out;
    // Software writes land on the acknowledging edge.
    if (wr)
    begin
      case (a)
        tmr_pkg::OFS_TMR0_CTRL: nxt.ctrl[0] = i_wb_dat[7:0];
        tmr_pkg::OFS_TMR1_CTRL:
          nxt.ctrl[1] = i_wb_dat[7:0] & tmr_pkg::CTL1_MASK;
        tmr_pkg::OFS_TMR0:
        begin
          nxt.pre[0] = i_wb_dat[7:0];
          if (!run[0])
            nxt.cnt[0] = i_wb_dat[7:0];
        end
        tmr_pkg::OFS_TMR1:
        begin
          nxt.pre[1] = i_wb_dat[7:0];
          if (!run[1])
            nxt.cnt[1] = i_wb_dat[7:0];
        end
        tmr_pkg::OFS_SYS_CTRL:
        begin
          nxt.pfd_en = i_wb_dat[tmr_pkg::SYS_PFD_EN];
          nxt.src = i_wb_dat[tmr_pkg::SYS_SRC];
        end
        tmr_pkg::OFS_INT_CTRL:
        begin
          nxt.ien = i_wb_dat[1:0];
          nxt.flag = i_wb_dat[5:4];
        end
        tmr_pkg::OFS_PORT:
        begin
          nxt.dir_in = i_wb_dat[1:0];
          nxt.odat = i_wb_dat[3:2];
          nxt.pull = i_wb_dat[5:4];
        end
        default: nxt.freq_divider_out = nxt.freq_divider_out;
      endcase
    end
    // A set from overflow wins over a software clear.
    nxt.flag = nxt.flag | nxt.ovf;
    // Wake only on overflows whose flag was still clear.
    nxt.wake = i_halted & |(nxt.ovf & ~st.flag);
  end

  // State register; the counters get a defined value though software
  // is expected to load them before starting.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.ctrl <= {tmr_pkg::CTL_RST & tmr_pkg::CTL1_MASK, tmr_pkg::CTL_RST};
      st.dir_in <= tmr_pkg::DIR_RST;
    end
    else
      st <= nxt;
  end

  // Bus outputs.
  assign o_wb_dat = st.dat;
  assign o_wb_ack = st.ack;
  // Requests need the enable; a halted overflow on a clear flag wakes without it.
  assign o_irq_req = st.flag & st.ien;
  assign o_wake = st.wake;
  // Pull-high stays as software set it in every mode.
  assign o_count_pullup = st.pull;
  // An input pin is never driven; a data bit of zero holds it low.
  assign o_pfd_pin_oe = ~st.dir_in;
  assign o_pfd_pin = st.pfd_en ? (st.odat & {2{st.freq_divider_out}}) : st.odat;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_cap_open(i);
    st.cap[i] && mode[i] == tmr_pkg::MODE_CAPTURE;
  endsequence
  sequence s_cap_close(i);
    st.cap[i] ##1 !st.cap[i] && !run[i];
  endsequence

  property p_cap_hold;
    s_cap_close(1) ##1 !wr [*3] |-> $stable(st.cnt[1]);
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("Capture count moved after stop.");

  property p_cap_edge;
    $rose(st.cap[1]) |-> $past(start_e[1]) && $past(run[1]);
  endproperty
  a_cap_edge: assert property (p_cap_edge)
    else $error("Capture opened without a start edge.");

  property p_cap_stop;
    s_cap_open(1) ##0 stop_e[1] && !(wr && a == tmr_pkg::OFS_TMR1_CTRL)
      |=> !run[1] && !st.cap[1];
  endproperty
  a_cap_stop: assert property (p_cap_stop)
    else $error("Stop edge did not clear run.");

  property p_reload;
    st.ovf[1] |-> st.cnt[1] == st.pre[1] && $past(st.cnt[1]) == 8'hFF;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Overflow without reload from all ones.");

  property p_flag;
    st.ovf[0] |-> st.flag[0] ##1 (st.flag[0] || $past(wr));
  endproperty
  a_flag: assert property (p_flag)
    else $error("Overflow did not set flag.");

  property p_pfd;
    st.ovf[0] && !st.src && $past(!st.src) |-> st.freq_divider_out != $past(st.freq_divider_out);
  endproperty
  a_pfd: assert property (p_pfd)
    else $error("Divider did not toggle on overflow.");

  property p_gate;
    st.pfd_en && !st.odat[1] |-> !o_pfd_pin[1];
  endproperty
  a_gate: assert property (p_gate)
    else $error("Divider pin high with data bit low.");

  property p_inhibit;
    req && a == tmr_pkg::OFS_TMR1 && !i_wb_we |=> $stable(st.cnt[1]);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("Counter moved during read.");

  property p_wake;
    i_halted && |(nxt.ovf & ~st.flag) |=> o_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Overflow failed to wake.");

  property p_no_wake;
    o_wake |-> $past(i_halted) && |(st.ovf & ~$past(st.flag));
  endproperty
  a_no_wake: assert property (p_no_wake)
    else $error("Wake with flag already set.");
endmodule : tmr_top
`default_nettype wire

// [verif/tmr_partner.sv]
// Far-side model: pulse source on the count pins, load on divider pins.
// Assumes the bench clock; the source changes its pins just after edges.
`timescale 1ns/1ps
`default_nettype none
module tmr_partner (
  // Clock.
  input wire logic i_clk,
  // Pins of the slice.
  input wire logic [1:0] i_pullup,
  input wire logic [1:0] i_pfd,
  input wire logic [1:0] i_pfd_oe,
  output logic [1:0] o_count_pin,
  output logic [1:0] o_pfd_lvl
);
  logic [1:0] drv = 2'b11;
  logic [1:0] lvl = 2'b10;
  logic [1:0] ext = 2'b11;

  // A released pin goes to its pull level, else to the inverse of its last.
  always_comb
  begin
    o_count_pin = (drv & lvl) | (~drv & (i_pullup | ~lvl));
    o_pfd_lvl = (i_pfd_oe & i_pfd) | (~i_pfd_oe & ext);
  end

  // One pulse of w cycles at level a, framed by the opposite level.
  task automatic pulse(input int i, input logic a, input int w);
    @(posedge i_clk);
    lvl[i] <= ~a;
    repeat (4) @(posedge i_clk);
    lvl[i] <= a;
    repeat (w) @(posedge i_clk);
    lvl[i] <= ~a;
    repeat (6) @(posedge i_clk);
  endtask : pulse
endmodule : tmr_partner
`default_nettype wire

// [verif/tmr_top_bench.sv]
// Self-checking bench for the timer slice: bus tasks and scenarios.
// Assumes tmr_top, tmr_pkg and the far-side model tmr_partner.
`timescale 1ns/1ps
`default_nettype none
module tmr_top_bench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic halted = 1'b0;
  logic [31:0] adr = 32'h0000_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] r;
  logic ack;
  logic wake;
  logic [1:0] cpin;
  logic [1:0] pup;
  logic [1:0] freq_divider_out;
  logic [1:0] oe;
  logic [1:0] plvl;
  logic [1:0] irq;
  int n_fail = 0;
  int n_checks = 0;
  int n_wake = 0;
  int n;
  int x;

  tmr_top i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_count_pin(cpin),
    .i_slow_tick(1'b0), .o_count_pullup(pup), .i_pfd_pin(plvl),
    .o_pfd_pin(freq_divider_out), .o_pfd_pin_oe(oe), .i_halted(halted),
    .o_irq_req(irq), .o_wake(wake)
  );
  tmr_partner u_far (
    .i_clk(i_clk), .i_pullup(pup), .i_pfd(freq_divider_out), .i_pfd_oe(oe),
    .o_count_pin(cpin), .o_pfd_lvl(plvl)
  );

  // Free-running clock.
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end

  // Wake pulses are counted away from the edge, where they are settled.
  always @(negedge i_clk)
  begin
    if (wake === 1'b1)
      n_wake++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Captured widths may be one tick off, as pin edges are resampled.
  task automatic near(input logic [7:0] g, input int e);
    n_checks++;
    if ((g >= 8'(e - 1) && g <= 8'(e + 1)) !== 1'b1)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, 8'(e));
    end
  endtask : near

  // Classic cycle; returns off the edge so callers sample settled outputs.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {24'h00_0000, a};
    wd <= d;
    do
    begin
      @(posedge i_clk);
      t++;
    end
    while (ack !== 1'b1 && t < 20);
    // Ack and read data are taken at the edge that sees ack high.
    q = rdat;
    cyc <= 1'b0;
    if (t >= 20)
      n_fail++;
    @(negedge i_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Cycles between two toggles of divider pin 0, after a first toggle.
  task automatic period();
    logic v;
    @(negedge i_clk);
    v = plvl[0];
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      while (plvl[0] === v && n < 4100)
      begin
        @(negedge i_clk);
        n++;
      end
      v = plvl[0];
    end
  endtask : period

  task automatic quiet();
    n = 0;
    repeat (64)
    begin
      @(negedge i_clk);
      if (plvl[0] !== 1'b0)
        n++;
    end
  endtask : quiet

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Hang guard, sized well above the longest divider sweep.
  initial
  begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    final_report();
  end

  // Scenarios in order: reset, divider, flags, wake, events, capture.
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(tmr_pkg::OFS_TMR0_CTRL);
    chk(q, 32'h0000_0008);
    rd(tmr_pkg::OFS_TMR1_CTRL);
    chk(q, 32'h0000_0008);
    rd(tmr_pkg::OFS_PORT);
    chk(q, 32'h0000_0303);
    rd(8'h40);
    chk(q, 32'h0000_0000);
    wr(tmr_pkg::OFS_TMR0, 32'h0000_00F0);
    wr(tmr_pkg::OFS_SYS_CTRL, 32'h0000_0001);
    wr(tmr_pkg::OFS_PORT, 32'h0000_0006);
    for (int p = 0; p < 8; p++)
    begin
      wr(tmr_pkg::OFS_TMR0_CTRL, 32'h0000_0090 | 32'(p));
      period();
      chk(32'(n), 32'(16 << p));
    end
    wr(tmr_pkg::OFS_TMR1, 32'h0000_00F0);
    wr(tmr_pkg::OFS_SYS_CTRL, 32'h0000_0003);
    wr(tmr_pkg::OFS_TMR1_CTRL, 32'h0000_0090);
    period();
    chk(32'(n), 32'h0000_0010);
    // A read of the running counter exercises the clock inhibit.
    rd(tmr_pkg::OFS_TMR1);
    chk(32'(q[7:0] >= 8'hF0), 32'h0000_0001);
    wr(tmr_pkg::OFS_PORT, 32'h0000_0002);
    quiet();
    chk(32'(n), 32'h0000_0000);
    @(posedge i_clk);
    u_far.ext <= 2'b00;
    wr(tmr_pkg::OFS_PORT, 32'h0000_000E);
    chk({30'h0, oe}, 32'h0000_0001);
    rd(tmr_pkg::OFS_PORT);
    chk(q & 32'h0000_0200, 32'h0000_0000);
    wr(tmr_pkg::OFS_PORT, 32'h0000_000F);
    quiet();
    chk({30'h0, oe} + 32'(n), 32'h0000_0000);
    wr(tmr_pkg::OFS_TMR0_CTRL, 32'h0000_0080);
    wr(tmr_pkg::OFS_TMR1_CTRL, 32'h0000_0080);
    rd(tmr_pkg::OFS_INT_CTRL);
    chk(q, 32'h0000_0030);
    wr(tmr_pkg::OFS_INT_CTRL, 32'h0000_0011);
    chk({30'h0, irq}, 32'h0000_0001);
    wr(tmr_pkg::OFS_INT_CTRL, 32'h0000_0000);
    @(posedge i_clk);
    halted <= 1'b1;
    wr(tmr_pkg::OFS_TMR0, 32'h0000_00F8);
    n_wake = 0;
    wr(tmr_pkg::OFS_TMR0_CTRL, 32'h0000_0090);
    repeat (40) @(posedge i_clk);
    chk(32'(n_wake), 32'h0000_0001);
    chk({30'h0, irq}, 32'h0000_0000);
    halted <= 1'b0;
    wr(tmr_pkg::OFS_TMR0_CTRL, 32'h0000_0000);
    wr(tmr_pkg::OFS_TMR0, 32'h0000_0000);
    for (int e = 0; e < 3; e++)
    begin
      wr(tmr_pkg::OFS_TMR0_CTRL, e < 2 ? 32'h50 | 32'(e << 3) : 32'h10);
      repeat (5) u_far.pulse(0, 1'b1, 4);
      rd(tmr_pkg::OFS_TMR0);
      chk(q, 32'(5 * (e < 2 ? e + 1 : 2)));
    end
    wr(tmr_pkg::OFS_PORT, 32'h0000_003F);
    chk({30'h0, pup}, 32'h0000_0003);
    wr(tmr_pkg::OFS_INT_CTRL, 32'h0000_0000);
    for (int k = 0; k < 3; k++)
    begin
      x = (k == 2) ? 240 : 0;
      wr(tmr_pkg::OFS_TMR1, 32'(x));
      wr(tmr_pkg::OFS_TMR1_CTRL, 32'h00D0 | 32'((k & 1) << 3));
      u_far.pulse(1, k[0], 40 - k * 8);
      rd(tmr_pkg::OFS_TMR1_CTRL);
      chk(q, 32'h00C0 | 32'((k & 1) << 3));
      // An overflow reloads the preload and counting carries on.
      x = x + 40 - k * 8;
      if (x > 255)
        x = x - 256 + 240;
      rd(tmr_pkg::OFS_TMR1);
      near(q[7:0], x);
      r = q;
      u_far.pulse(1, k[0], 10);
      rd(tmr_pkg::OFS_TMR1);
      chk(q, r);
    end
    rd(tmr_pkg::OFS_INT_CTRL);
    chk(q, 32'h0000_0020);
    final_report();
  end
endmodule : tmr_top_bench
`default_nettype wire
